// ==== design/hdc_controller_port.sv ====
// controller serial port for the user-defined protocol, wishbone slave
`timescale 1ns/1ps
module hdc_controller_port
  import hdc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // mode indication
  output logic nativeMode,
  // bus side
  hdc_link_if.host link
);

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] val, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i]) r[8*i +: 8] = val[8*i +: 8];
    return r;
  endfunction : merge

  // transmit block memory
  logic [7:0] txMem [256];

  // bus and register state
  logic ack_r, ack_nxt;
  logic [31:0] datO_r, datO_nxt;
  logic run_r, run_nxt;
  logic nat_r;
  logic [15:0] baud_r, baud_nxt;      // clocks per bit
  logic [CNT_W-1:0] hold_r, hold_nxt; // quiet time before a send
  logic [31:0] msg_r, msg_nxt;        // message framing setup
  logic [7:0] fill_r, fill_nxt;
  logic txDone_r, txDone_nxt;
  logic rxChar_r, rxChar_nxt;
  logic msgDone_r, msgDone_nxt;
  logic wr, rd, push, goReq;
  logic [2:0] clr;

  // transmit state
  hdc_tx_t txSt_r, txSt_nxt;
  logic [7:0] txLen_r, txLen_nxt, txIdx_r, txIdx_nxt;
  logic [3:0] txBit_r, txBit_nxt;
  logic [15:0] txCnt_r, txCnt_nxt;
  logic [9:0] txSh_r, txSh_nxt;
  logic hData_r, hData_nxt, hOe_r, hOe_nxt;
  logic [CNT_W-1:0] quiet_r, quiet_nxt;
  logic txFinish;

  // receive state
  hdc_rx_t rxSt_r, rxSt_nxt;
  logic [15:0] rxCnt_r, rxCnt_nxt;
  logic [2:0] rxBit_r, rxBit_nxt;
  logic [7:0] rxSh_r, rxSh_nxt, last_r, last_nxt, len_r, len_nxt;
  logic inMsg_r, inMsg_nxt;
  logic [23:0] gap_r, gap_nxt, gapLimit;
  logic rxGot, msgEnd;
  logic [7:0] rxByte;

  // a request is answered one cycle after it arrives
  assign wr = ack_nxt && wbWe;
  assign rd = ack_nxt && !wbWe;
  assign push = wr && wbAdr == OFS_TXBUF && wbSel[0] && run_r
    && txSt_r == TX_IDLE && fill_r != MAX_TX_LEN;
  // a zero length is ignored; eight bits cap a block at 255
  assign goReq = wr && wbAdr == OFS_TXGO && wbSel[0] && run_r
    && txSt_r == TX_IDLE && wbDatI[7:0] != 8'h00;
  assign clr = (wr && wbAdr == OFS_STATUS && wbSel[0]) ? wbDatI[2:0] : 3'h0;
  assign gapLimit = msg_r[MSG_IDLE_LSB +: 8] * baud_r;

  // register file, address decode and sticky event flags
  always_comb
  begin
    ack_nxt = wbCyc && wbStb && !ack_r;
    datO_nxt = 32'h0;
    run_nxt = run_r;
    baud_nxt = baud_r;
    hold_nxt = hold_r;
    msg_nxt = msg_r;
    fill_nxt = fill_r;
    if (wr)
    begin
      if (wbAdr == OFS_CTRL && wbSel[0])
        run_nxt = wbDatI[0];
      else if (wbAdr == OFS_BAUD)
        baud_nxt = 16'(merge({16'h0, baud_r}, wbDatI, wbSel));
      else if (wbAdr == OFS_HOLD)
        hold_nxt = CNT_W'(merge({10'h0, hold_r}, wbDatI, wbSel));
      else if (wbAdr == OFS_MSG)
        msg_nxt = merge(msg_r, wbDatI, wbSel);
    end
    if (rd)
    begin
      if (wbAdr == OFS_CTRL)
        datO_nxt = {31'h0, run_r};
      else if (wbAdr == OFS_BAUD)
        datO_nxt = {16'h0, baud_r};
      else if (wbAdr == OFS_HOLD)
        datO_nxt = {10'h0, hold_r};
      else if (wbAdr == OFS_MSG)
        datO_nxt = msg_r;
      else if (wbAdr == OFS_TXBUF)
        datO_nxt = {24'h0, fill_r};
      else if (wbAdr == OFS_STATUS)
        datO_nxt = {27'h0, run_r, txSt_r != TX_IDLE, msgDone_r,
          rxChar_r, txDone_r};
      else if (wbAdr == OFS_RXDATA)
        datO_nxt = {16'h0, len_r, last_r};
    end
    // fill empties when a block ends or the port stops
    if (txFinish || !run_r)
      fill_nxt = 8'h00;
    else if (push)
      fill_nxt = fill_r + 1'b1;
    // set wins over a clear in the same cycle
    txDone_nxt = txFinish | (txDone_r & ~clr[ST_TXDONE]);
    rxChar_nxt = rxGot | (rxChar_r & ~clr[ST_RXCHAR]);
    msgDone_nxt = msgEnd | (msgDone_r & ~clr[ST_MSGDONE]);
  end

  // register file registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_r <= 1'b0;
      datO_r <= 32'h0;
      run_r <= 1'b0;
      nat_r <= 1'b1;
      baud_r <= DEF_BAUD_DIV;
      hold_r <= DEF_HOLD;
      msg_r <= {DEF_IDLE_BITS, 24'h0};
      fill_r <= 8'h00;
      txDone_r <= 1'b0;
      rxChar_r <= 1'b0;
      msgDone_r <= 1'b0;
    end
    else
    begin
      ack_r <= ack_nxt;
      datO_r <= datO_nxt;
      run_r <= run_nxt;
      nat_r <= !run_nxt;
      baud_r <= baud_nxt;
      hold_r <= hold_nxt;
      msg_r <= msg_nxt;
      fill_r <= fill_nxt;
      txDone_r <= txDone_nxt;
      rxChar_r <= rxChar_nxt;
      msgDone_r <= msgDone_nxt;
    end
  end

  // block memory is written only, never reset
  always_ff @(posedge clk)
  begin
    if (push)
      txMem[fill_r] <= wbDatI[7:0];
  end

  // transmit sequencer: wait for bus quiet, then send 8N1 frames
  always_comb
  begin
    txSt_nxt = txSt_r;
    txLen_nxt = txLen_r;
    txIdx_nxt = txIdx_r;
    txBit_nxt = txBit_r;
    txCnt_nxt = txCnt_r;
    txSh_nxt = txSh_r;
    txFinish = 1'b0;
    case (txSt_r)
      TX_IDLE:
        if (goReq)
        begin
          txLen_nxt = wbDatI[7:0];
          txIdx_nxt = 8'h00;
          txSt_nxt = TX_WAIT;
        end
      TX_WAIT:
        // the converter needs this long to give the bus back
        if (quiet_r >= hold_r)
        begin
          txSh_nxt = {1'b1, txMem[txIdx_r], 1'b0};
          txBit_nxt = 4'h0;
          txCnt_nxt = baud_r - 1'b1;
          txSt_nxt = TX_SEND;
        end
      TX_SEND:
        if (txCnt_r != 16'h0)
          txCnt_nxt = txCnt_r - 1'b1;
        else if (txBit_r != 4'h9)
        begin
          txSh_nxt = {1'b1, txSh_r[9:1]};
          txBit_nxt = txBit_r + 1'b1;
          txCnt_nxt = baud_r - 1'b1;
        end
        else if (txIdx_r + 1'b1 == txLen_r)
        begin
          txFinish = 1'b1;
          txSt_nxt = TX_IDLE;
        end
        else
        begin
          txIdx_nxt = txIdx_r + 1'b1;
          txSh_nxt = {1'b1, txMem[txIdx_nxt], 1'b0};
          txBit_nxt = 4'h0;
          txCnt_nxt = baud_r - 1'b1;
        end
      default: txSt_nxt = TX_IDLE;
    endcase
    // leaving run drops any block in flight
    if (!run_r)
    begin
      txSt_nxt = TX_IDLE;
      txFinish = 1'b0;
    end
    hOe_nxt = (txSt_nxt == TX_SEND);
    hData_nxt = (txSt_nxt == TX_SEND) ? txSh_nxt[0] : 1'b1;
    // quiet time restarts on any space level we did not drive
    if (!hOe_r && !link.busLine)
      quiet_nxt = '0;
    else if (quiet_r != {CNT_W{1'b1}})
      quiet_nxt = quiet_r + 1'b1;
    else
      quiet_nxt = quiet_r;
  end

  // transmit registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txSt_r <= TX_IDLE;
      txLen_r <= 8'h00;
      txIdx_r <= 8'h00;
      txBit_r <= 4'h0;
      txCnt_r <= 16'h0;
      txSh_r <= 10'h3FF;
      hData_r <= 1'b1;
      hOe_r <= 1'b0;
      quiet_r <= '0;
    end
    else
    begin
      txSt_r <= txSt_nxt;
      txLen_r <= txLen_nxt;
      txIdx_r <= txIdx_nxt;
      txBit_r <= txBit_nxt;
      txCnt_r <= txCnt_nxt;
      txSh_r <= txSh_nxt;
      hData_r <= hData_nxt;
      hOe_r <= hOe_nxt;
      quiet_r <= quiet_nxt;
    end
  end

  // receive sequencer and message framing, samples mid-bit
  always_comb
  begin
    rxSt_nxt = rxSt_r;
    rxCnt_nxt = rxCnt_r;
    rxBit_nxt = rxBit_r;
    rxSh_nxt = rxSh_r;
    last_nxt = last_r;
    len_nxt = len_r;
    inMsg_nxt = inMsg_r;
    rxGot = 1'b0;
    msgEnd = 1'b0;
    rxByte = rxSh_r;
    gap_nxt = (gap_r != 24'hFFFFFF) ? gap_r + 1'b1 : gap_r;
    if (rxCnt_r != 16'h0)
      rxCnt_nxt = rxCnt_r - 1'b1;
    case (rxSt_r)
      RX_IDLE:
        if (!link.busLine && !hOe_r)
        begin
          rxCnt_nxt = {1'b0, baud_r[15:1]};
          rxSt_nxt = RX_START;
        end
      RX_START:
        if (rxCnt_r == 16'h0)
        begin
          rxSt_nxt = link.busLine ? RX_IDLE : RX_DATA;
          rxCnt_nxt = baud_r - 1'b1;
          rxBit_nxt = 3'h0;
        end
      RX_DATA:
        if (rxCnt_r == 16'h0)
        begin
          rxSh_nxt = {link.busLine, rxSh_r[7:1]};
          rxBit_nxt = rxBit_r + 1'b1;
          rxCnt_nxt = baud_r - 1'b1;
          if (rxBit_r == 3'h7)
            rxSt_nxt = RX_STOP;
        end
      RX_STOP:
        if (rxCnt_r == 16'h0)
        begin
          rxSt_nxt = RX_IDLE;
          rxGot = link.busLine;
          gap_nxt = 24'h0;
        end
      default: rxSt_nxt = RX_IDLE;
    endcase
    if (rxGot)
    begin
      last_nxt = rxByte;
      if (!inMsg_r)
      begin
        // start on the start character, or on any one if disabled
        if (!msg_r[MSG_STARTEN] || rxByte == msg_r[7:0])
        begin
          inMsg_nxt = 1'b1;
          len_nxt = 8'h01;
        end
      end
      else
      begin
        len_nxt = (len_r != 8'hFF) ? len_r + 1'b1 : len_r;
        if (msg_r[MSG_ENDEN] && rxByte == msg_r[MSG_END_LSB +: 8])
        begin
          inMsg_nxt = 1'b0;
          msgEnd = 1'b1;
        end
      end
    end
    else if (inMsg_r && gapLimit != 24'h0 && gap_r >= gapLimit
      && rxSt_r == RX_IDLE)
    begin
      // idle line ends the message
      inMsg_nxt = 1'b0;
      msgEnd = 1'b1;
    end
    if (!run_r)
    begin
      rxSt_nxt = RX_IDLE;
      inMsg_nxt = 1'b0;
      rxGot = 1'b0;
      msgEnd = 1'b0;
    end
  end

  // receive registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxSt_r <= RX_IDLE;
      rxCnt_r <= 16'h0;
      rxBit_r <= 3'h0;
      rxSh_r <= 8'h00;
      last_r <= 8'h00;
      len_r <= 8'h00;
      inMsg_r <= 1'b0;
      gap_r <= 24'h0;
    end
    else
    begin
      rxSt_r <= rxSt_nxt;
      rxCnt_r <= rxCnt_nxt;
      rxBit_r <= rxBit_nxt;
      rxSh_r <= rxSh_nxt;
      last_r <= last_nxt;
      len_r <= len_nxt;
      inMsg_r <= inMsg_nxt;
      gap_r <= gap_nxt;
    end
  end

  // outputs from registers
  assign wbAck = ack_r;
  assign wbDatO = datO_r;
  assign nativeMode = nat_r;
  assign link.hostData = hData_r;
  assign link.hostOe = hOe_r;

endmodule : hdc_controller_port

// ==== design/hdc_converter.sv ====
// direction controller at the converter end of the half-duplex link
`timescale 1ns/1ps
// Operation
// - idle or downstream traffic keeps receive direction
// - transmit direction drives serial data onto bus
// - activity on serial input switches to transmit
// - return to receive after idle turnaround
// - turnaround time follows selected baud rate
// - decode three-bit rate code per table
// - only rates 1200 to 115200 supported
// - protocol switch zero enables pass-through operation
// - role switch picks local or remote pinout
// - controller delays reply by turnaround time
// - controller delays next request by turnaround
// - transmit block up to 255, done event
// - controller flags every received character
// - message framed by characters or idle time
// - run state only; stop aborts traffic
// - rate code comes from switches one to three
module hdc_converter
  import hdc_pkg::*;
#(
  // clocks per microsecond of turnaround, lower it to shorten simulation
  parameter int unsigned US_CYC = CLK_MHZ,
  // turnaround counts per rate
  parameter int unsigned TURN_115200 = TA_115200_US * US_CYC,
  parameter int unsigned TURN_57600 = TA_57600_US * US_CYC,
  parameter int unsigned TURN_38400 = TA_38400_US * US_CYC,
  parameter int unsigned TURN_19200 = TA_19200_US * US_CYC,
  parameter int unsigned TURN_9600 = TA_9600_US * US_CYC,
  parameter int unsigned TURN_4800 = TA_4800_US * US_CYC,
  parameter int unsigned TURN_2400 = TA_2400_US * US_CYC,
  parameter int unsigned TURN_1200 = TA_1200_US * US_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // static switches
  input wire logic [2:0] rateSwitch,
  input wire logic protoSwitch,
  input wire logic roleSwitch,
  // serial pin 2
  input wire logic pin2In,
  output logic pin2Out,
  output logic pin2Oe,
  // serial pin 3
  input wire logic pin3In,
  output logic pin3Out,
  output logic pin3Oe,
  // handshake toward a modem
  output logic rtsOut,
  // status
  output logic txMode,
  output logic modeFault,
  // bus side
  hdc_link_if.dev link
);

  // turnaround cycles for a rate code
  // every code maps to one of the eight supported rates
  function automatic logic [CNT_W-1:0] turnCycles(input logic [2:0] code);
    logic [CNT_W-1:0] c;
    c = CNT_W'(TURN_38400);
    case (code)
      RATE_115200: c = CNT_W'(TURN_115200);
      RATE_57600: c = CNT_W'(TURN_57600);
      RATE_38400: c = CNT_W'(TURN_38400);
      RATE_19200: c = CNT_W'(TURN_19200);
      RATE_9600: c = CNT_W'(TURN_9600);
      RATE_4800: c = CNT_W'(TURN_4800);
      RATE_2400: c = CNT_W'(TURN_2400);
      RATE_1200: c = CNT_W'(TURN_1200);
    endcase
    return c;
  endfunction : turnCycles

  // direction state and idle counter
  hdc_dir_t dir_r;
  hdc_dir_t dir_nxt;
  logic [CNT_W-1:0] idle_r;
  logic [CNT_W-1:0] idle_nxt;

  // registered pin drive
  logic devData_r;
  logic devData_nxt;
  logic devOe_r;
  logic devOe_nxt;
  logic rxOut_r;     // level sent to the serial device
  logic rxOut_nxt;
  logic pin2Oe_r;
  logic pin2Oe_nxt;
  logic pin3Oe_r;
  logic pin3Oe_nxt;
  logic rts_r;
  logic rts_nxt;
  logic txMode_r;
  logic txMode_nxt;
  logic fault_r;
  logic fault_nxt;

  // decoded inputs
  logic serialIn;    // data from the serial device
  logic charActive;  // serial input at space level
  logic freeportOn;  // pass-through mode selected
  logic [CNT_W-1:0] turnLimit;

  // local mode takes device data on pin 3, remote mode on pin 2
  assign serialIn = (roleSwitch == ROLE_REMOTE) ? pin2In : pin3In;
  // a start bit or a zero data bit both count as activity
  assign charActive = ~serialIn;
  // native network mode is not handled by this block
  assign freeportOn = (protoSwitch == PROTO_FREEPORT);
  // switches one to three form the rate code
  assign turnLimit = turnCycles(rateSwitch);

  // direction sequencer
  // switching is decided from the raw sample so that the bus driver
  // turns on at the same edge that forwards the first space bit
  always_comb
  begin
    dir_nxt = dir_r;
    idle_nxt = idle_r;
    if (!freeportOn)
    begin
      // wrong protocol setting: stay off the bus
      dir_nxt = DIR_RECV;
      idle_nxt = '0;
    end
    else
    begin
      case (dir_r)
        DIR_RECV:
        begin
          // idle or downstream traffic leaves us receiving
          if (charActive)
          begin
            dir_nxt = DIR_XMIT;
            idle_nxt = '0;
          end
        end
        DIR_XMIT:
        begin
          if (charActive)
          begin
            // each space level restarts the quiet time
            idle_nxt = '0;
          end
          else if (idle_r >= turnLimit - 1'b1)
          begin
            // quiet for a whole turnaround, hand the bus back
            dir_nxt = DIR_RECV;
            idle_nxt = '0;
          end
          else
          begin
            idle_nxt = idle_r + 1'b1;
          end
        end
        default:
        begin
          dir_nxt = DIR_RECV;
          idle_nxt = '0;
        end
      endcase
    end
  end

  // direction registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dir_r <= DIR_RECV;
      idle_r <= '0;
    end
    else
    begin
      dir_r <= dir_nxt;
      idle_r <= idle_nxt;
    end
  end

  // pin drive values, one cycle of latency in each direction
  always_comb
  begin
    // bus driver follows the serial input while transmitting
    devOe_nxt = (dir_nxt == DIR_XMIT);
    devData_nxt = (dir_nxt == DIR_XMIT) ? serialIn : 1'b1;
    // bus traffic goes to the serial device while receiving
    rxOut_nxt = (dir_nxt == DIR_RECV) ? link.busLine : 1'b1;
    // local mode sends on pin 2, remote mode on pin 3
    pin2Oe_nxt = (roleSwitch == ROLE_LOCAL);
    pin3Oe_nxt = (roleSwitch == ROLE_REMOTE);
    // handshake line is only supplied in remote mode
    rts_nxt = (roleSwitch == ROLE_REMOTE);
    txMode_nxt = (dir_nxt == DIR_XMIT);
    fault_nxt = !freeportOn;
  end

  // pin registers; driver stays off and lines idle high in reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      devOe_r <= 1'b0;
      devData_r <= 1'b1;
      rxOut_r <= 1'b1;
      pin2Oe_r <= 1'b0;
      pin3Oe_r <= 1'b0;
      rts_r <= 1'b0;
      txMode_r <= 1'b0;
      fault_r <= 1'b0;
    end
    else
    begin
      devOe_r <= devOe_nxt;
      devData_r <= devData_nxt;
      rxOut_r <= rxOut_nxt;
      pin2Oe_r <= pin2Oe_nxt;
      pin3Oe_r <= pin3Oe_nxt;
      rts_r <= rts_nxt;
      txMode_r <= txMode_nxt;
      fault_r <= fault_nxt;
    end
  end

  // outputs straight from the registers
  assign link.devData = devData_r;
  assign link.devOe = devOe_r;
  assign pin2Out = rxOut_r;
  assign pin3Out = rxOut_r;
  assign pin2Oe = pin2Oe_r;
  assign pin3Oe = pin3Oe_r;
  assign rtsOut = rts_r;
  assign txMode = txMode_r;
  assign modeFault = fault_r;

endmodule : hdc_converter

// ==== design/hdc_link_if.sv ====
// half-duplex differential bus shared by converter and controller port
`timescale 1ns/1ps
interface hdc_link_if;
  logic devData;   // converter driver data
  logic devOe;     // converter driver enable
  logic hostData;  // controller driver data
  logic hostOe;    // controller driver enable
  logic busLine;   // resolved level, idle high when nobody drives

  // converter wins a collision; both driving is a protocol error anyway
  assign busLine = devOe ? devData : (hostOe ? hostData : 1'b1);

  modport dev (input busLine, output devData, output devOe);
  modport host (input busLine, output hostData, output hostOe);
endinterface : hdc_link_if

// ==== design/hdc_pkg.sv ====
// shared constants and types for the half-duplex direction control pair
package hdc_pkg;

  // system clock rate in MHz (4 ns period)
  localparam int unsigned CLK_MHZ = 250;

  // three-bit rate switch codes, a one means switch up
  localparam logic [2:0] RATE_115200 = 3'h6;
  localparam logic [2:0] RATE_57600 = 3'h7;
  localparam logic [2:0] RATE_38400 = 3'h0;
  localparam logic [2:0] RATE_19200 = 3'h1;
  localparam logic [2:0] RATE_9600 = 3'h2;
  localparam logic [2:0] RATE_4800 = 3'h3;
  localparam logic [2:0] RATE_2400 = 3'h4;
  localparam logic [2:0] RATE_1200 = 3'h5;

  // turnaround times in microseconds
  localparam int unsigned TA_115200_US = 150;
  localparam int unsigned TA_57600_US = 300;
  localparam int unsigned TA_38400_US = 500;
  localparam int unsigned TA_19200_US = 1000;
  localparam int unsigned TA_9600_US = 2000;
  localparam int unsigned TA_4800_US = 4000;
  localparam int unsigned TA_2400_US = 7000;
  localparam int unsigned TA_1200_US = 14000;

  // turnaround times as clock cycles
  localparam int unsigned TA_115200_CYC = TA_115200_US * CLK_MHZ;
  localparam int unsigned TA_57600_CYC = TA_57600_US * CLK_MHZ;
  localparam int unsigned TA_38400_CYC = TA_38400_US * CLK_MHZ;
  localparam int unsigned TA_19200_CYC = TA_19200_US * CLK_MHZ;
  localparam int unsigned TA_9600_CYC = TA_9600_US * CLK_MHZ;
  localparam int unsigned TA_4800_CYC = TA_4800_US * CLK_MHZ;
  localparam int unsigned TA_2400_CYC = TA_2400_US * CLK_MHZ;
  localparam int unsigned TA_1200_CYC = TA_1200_US * CLK_MHZ;

  // idle counter width, holds the longest turnaround
  localparam int CNT_W = 22;

  // switch meanings
  localparam logic PROTO_FREEPORT = 1'b0;
  localparam logic ROLE_LOCAL = 1'b0;
  localparam logic ROLE_REMOTE = 1'b1;

  // controller port register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BAUD = 8'h04;
  localparam logic [7:0] OFS_HOLD = 8'h08;
  localparam logic [7:0] OFS_MSG = 8'h0C;
  localparam logic [7:0] OFS_TXBUF = 8'h10;
  localparam logic [7:0] OFS_TXGO = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_RXDATA = 8'h1C;

  // status bit positions
  localparam int ST_TXDONE = 0;
  localparam int ST_RXCHAR = 1;
  localparam int ST_MSGDONE = 2;
  localparam int ST_TXBUSY = 3;
  localparam int ST_RUN = 4;

  // message config field positions
  localparam int MSG_END_LSB = 8;
  localparam int MSG_STARTEN = 16;
  localparam int MSG_ENDEN = 17;
  localparam int MSG_IDLE_LSB = 24;

  // reset values
  localparam logic [15:0] DEF_BAUD_DIV = 16'(CLK_MHZ * 1000000 / 9600);
  localparam logic [CNT_W-1:0] DEF_HOLD = CNT_W'(TA_1200_CYC);
  localparam logic [7:0] DEF_IDLE_BITS = 8'h14;

  // largest block per transmit
  localparam logic [7:0] MAX_TX_LEN = 8'hFF;

  // direction of the converter
  typedef enum logic {DIR_RECV, DIR_XMIT} hdc_dir_t;
  // controller transmit and receive sequencers
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} hdc_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} hdc_rx_t;

endpackage : hdc_pkg

// ==== tb/half_duplex_direction_control_tb.sv ====
// bench driving both ends of the half-duplex link
`timescale 1ns/1ps
module half_duplex_direction_control_tb;
  import hdc_pkg::*;
  logic clk = 0, rst_n = 0, protoSw = 0, roleSw = 0, p2 = 1, p3 = 1;
  logic cyc = 0, stb = 0, we = 0, ack, nat, p2o, p2e, p3o, p3e, rts, txm, flt;
  logic [2:0] rateSw = 3'h6;
  logic [3:0] sel = 4'hF, selReq = 4'hF;
  logic sawLow = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, datO, q;
  int num_errors = 0, checked = 0, cycN = 0, n;
  // turnaround by rate code, in cycles at one clock per microsecond
  int tbl[8] = '{TA_38400_US, TA_19200_US, TA_9600_US, TA_4800_US,
    TA_2400_US, TA_1200_US, TA_115200_US, TA_57600_US};
  hdc_link_if link();
  always #2 clk = ~clk;
  // one clock per microsecond keeps every turnaround short
  hdc_converter #(.US_CYC(1)) u_hdc_converter (.clk(clk), .rst_n(rst_n),
    .rateSwitch(rateSw), .protoSwitch(protoSw), .roleSwitch(roleSw),
    .pin2In(p2), .pin2Out(p2o), .pin2Oe(p2e), .pin3In(p3), .pin3Out(p3o),
    .pin3Oe(p3e), .rtsOut(rts), .txMode(txm), .modeFault(flt), .link(link));
  hdc_controller_port u_hdc_controller_port (.clk(clk), .rst_n(rst_n),
    .wbCyc(cyc), .wbStb(stb), .wbWe(we), .wbAdr(adr), .wbSel(sel),
    .wbDatI(dat), .wbDatO(datO), .wbAck(ack), .nativeMode(nat), .link(link));
  hdc_checker u_hdc_checker (.clk(clk),
    .rst_n(rst_n), .devData(link.devData), .devOe(link.devOe),
    .hostData(link.hostData), .hostOe(link.hostOe), .busLine(link.busLine));
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : ck
  // one classic wishbone cycle, read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    sel <= selReq;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = datO;
    cyc <= 0;
    stb <= 0;
  endtask : wb
  // two lows five cycles apart, then time the return to receive
  task automatic turn(input int e);
    @(posedge clk);
    p3 <= 0;
    @(posedge clk);
    p3 <= 1;
    repeat (5) @(posedge clk);
    p3 <= 0;
    @(posedge clk);
    p3 <= 1;
    #1 ck(link.devOe, 1);
    ck(link.devData, 0);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      #1;
    end
    while (link.devOe === 1'b1 && n < 20000);
    ck(n, e);
  endtask : turn
  // 8N1 character at eight clocks a bit on the serial input
  task automatic ser(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      p3 <= f[i];
      repeat (8) @(posedge clk);
    end
  endtask : ser
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  // a host frame must reach the serial pins while receiving
  always @(posedge clk)
    if (link.hostOe && !p2o && !p3o)
      sawLow <= 1;
  // hang guard, the tests need about thirty thousand cycles
  always @(posedge clk)
  begin
    cycN++;
    if (cycN == 40000)
    begin
      num_errors++;
      final_report();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    #1 ck({link.devOe, txm, flt, nat}, 4'h1);
    @(posedge clk);
    #1 ck({p2e, p3e, rts}, 3'h4);
    for (int c = 0; c < 8; c++)
    begin
      rateSw <= c[2:0];
      repeat (3) @(posedge clk);
      turn(tbl[c]);
    end
    rateSw <= 3'h6;
    wb(1, OFS_BAUD, 8);
    wb(1, OFS_HOLD, 200);
    selReq = 4'hE;
    wb(1, OFS_HOLD, 32'h000000FF);
    selReq = 4'hF;
    wb(0, OFS_HOLD, 0);
    ck(q, 200);
    wb(1, OFS_CTRL, 1);
    ck(nat, 0);
    ser(8'hA5);
    repeat (40) @(posedge clk);
    wb(0, OFS_STATUS, 0);
    ck(q[ST_RXCHAR], 1);
    wb(0, OFS_RXDATA, 0);
    ck(q[15:0], 16'h01A5);
    wb(1, OFS_TXBUF, 8'h3C);
    wb(1, OFS_TXBUF, 8'hC3);
    wb(0, OFS_TXBUF, 0);
    ck(q, 2);
    wb(1, OFS_TXGO, 2);
    n = 0;
    do
    begin
      wb(0, OFS_STATUS, 0);
      n++;
    end
    while (q[ST_TXDONE] !== 1'b1 && n < 300);
    ck(q[ST_TXDONE], 1);
    ck(q[ST_MSGDONE], 1);
    ck(sawLow, 1);
    wb(0, 8'h40, 0);
    ck(q, 0);
    wb(1, OFS_CTRL, 0);
    ck(nat, 1);
    wb(1, OFS_TXBUF, 8'h11);
    wb(0, OFS_TXBUF, 0);
    ck(q, 0);
    roleSw <= 1;
    repeat (3) @(posedge clk);
    ck({p3e, rts}, 2'h3);
    p2 <= 0;
    @(posedge clk);
    p2 <= 1;
    #1 ck(link.devOe, 1);
    repeat (200) @(posedge clk);
    protoSw <= 1;
    repeat (3) @(posedge clk);
    p2 <= 0;
    repeat (2) @(posedge clk);
    p2 <= 1;
    #1 ck({link.devOe, flt}, 2'h1);
    final_report();
  end
endmodule : half_duplex_direction_control_tb

// ==== tb/hdc_checker.sv ====
// link checks between the converter and the controller port
`timescale 1ns/1ps
module hdc_checker
  import hdc_pkg::*;
#(
  // shortest turnaround in use, at one clock per microsecond
  parameter int unsigned MIN_TURN = TA_115200_US,
  // host quiet wait before a send
  parameter int unsigned HOLD = 200
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link signals
  input wire logic devData,
  input wire logic devOe,
  input wire logic hostData,
  input wire logic hostOe,
  input wire logic busLine
);
  int unsigned hiCnt_r, hiCnt_nxt; // idle samples while transmitting
  int unsigned lowAge_r, lowAge_nxt; // cycles since a foreign low
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // counters mirror what each end should be timing
  always_comb
  begin
    hiCnt_nxt = (devOe && devData) ? hiCnt_r + 1 : 0;
    lowAge_nxt = (!busLine && !hostOe) ? 0 : lowAge_r + 1;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hiCnt_r <= 0;
      lowAge_r <= 0;
    end
    else
    begin
      hiCnt_r <= hiCnt_nxt;
      lowAge_r <= lowAge_nxt;
    end
  end
  // start bit of the host lasts at least four cycles
  sequence startBit;
    !hostData [*4];
  endsequence
  turn_on_a: assert property ($rose(devOe) |-> !devData)
    else $error("converter did not start on a low");
  turn_back_a: assert property ($fell(devOe) |-> hiCnt_r >= MIN_TURN - 1)
    else $error("converter turned back too early");
  restart_idle_a: assert property (devOe && !devData |=> devOe)
    else $error("low did not keep transmit direction");
  no_clash_a: assert property (!(devOe && hostOe))
    else $error("both ends drive the bus");
  host_wait_a: assert property ($rose(hostOe) |-> lowAge_r >= HOLD - 2)
    else $error("host sent before its quiet wait");
  host_start_a: assert property ($rose(hostOe) |-> startBit)
    else $error("host frame lacks a start bit");
  host_stop_a: assert property ($fell(hostOe) |-> $past(hostData))
    else $error("host released without a stop bit");
  bus_follow_a: assert property (devOe |-> busLine == devData)
    else $error("bus does not carry converter data");
  bus_idle_a: assert property (!devOe && !hostOe |-> busLine)
    else $error("released bus not high");
endmodule : hdc_checker
